/* File: spr_route_enable.sv */
// Serial path router and driver enable control with an AXI4-Lite register slave.
`include "spr_params.svh"
module spr_route_enable
   import spr_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire spr_chan_t   primary_serial_in,
   input  wire spr_chan_t   secondary_serial_in,
   input  wire spr_chan_t   tx_serial_data,
   output spr_chan_t        cdr_serial_in,
   output spr_en_t          serial_driver_out,
   output spr_en_t          serial_driver_en
);

   // Write channel holding registers; address and data may arrive in either order.
   logic        aw_held_r;
   logic [7:0]  aw_addr_r;
   logic        w_held_r;
   spr_word_t   w_data_r;
   logic [3:0]  w_strb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   spr_word_t   rdata_r;
   logic [1:0]  rresp_r;
   spr_word_t   ctrl_r;
   spr_en_t     enbus_r;
   spr_chan_t   cdr_r;
   spr_en_t     drv_out_r;

   wire logic      aw_take   = s_axi_awvalid && s_axi_awready;
   wire logic      w_take    = s_axi_wvalid && s_axi_wready;
   wire logic      ar_take   = s_axi_arvalid && s_axi_arready;
   wire logic      do_write  = aw_held_r && w_held_r && !bvalid_r;
   wire logic      wr_ctrl   = do_write && (aw_addr_r == `SPR_CTRL_OFF);
   wire logic      wr_enbus  = do_write && (aw_addr_r == `SPR_ENBUS_OFF);
   wire logic      wr_status = do_write && (aw_addr_r == `SPR_STATUS_OFF);
   wire logic      wr_hit    = wr_ctrl || wr_enbus || wr_status;
   wire spr_en_t   latch_q;
   wire logic      lb        = ctrl_r[`SPR_CTRL_LOOP_BIT];
   wire spr_chan_t sel       = ctrl_r[`SPR_CTRL_SEL_LSB +: 4];
   wire logic      le        = ctrl_r[`SPR_CTRL_LE_BIT];
   wire spr_word_t status_w  = {23'h00_0000, lb, latch_q};

   // Writes merge the held data by byte lane; unused control bits always read back as zero.
   // Writes to the status word are accepted and dropped, so software sees no error for it.
   wire spr_word_t ctrl_nxt  = spr_merge(ctrl_r, w_data_r, w_strb_r) & `SPR_CTRL_MASK;
   wire spr_word_t enbus_wd  = spr_merge({24'h00_0000, enbus_r}, w_data_r, w_strb_r);
   wire spr_en_t   enbus_nxt = enbus_wd[7:0];

   // Read decode; an unmapped offset reads zero with a slave error.
   wire spr_word_t rd_word   = (s_axi_araddr == `SPR_CTRL_OFF)   ? ctrl_r :
                               (s_axi_araddr == `SPR_ENBUS_OFF)  ? {24'h00_0000, enbus_r} :
                               (s_axi_araddr == `SPR_STATUS_OFF) ? status_w : 32'h0000_0000;
   wire logic      rd_hit    = (s_axi_araddr == `SPR_CTRL_OFF) ||
                               (s_axi_araddr == `SPR_ENBUS_OFF) ||
                               (s_axi_araddr == `SPR_STATUS_OFF);

   // Serial routing: loopback overrides the selector so the pins can never reach recovery.
   wire spr_chan_t ext_in    = (sel & primary_serial_in) | (~sel & secondary_serial_in);
   wire spr_chan_t cdr_nxt   = lb ? tx_serial_data : ext_in;
   // Both drivers of a channel carry the same stream; loopback holds them at one.
   wire spr_en_t   drv_nxt   = lb ? 8'hff : {tx_serial_data, tx_serial_data};

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign cdr_serial_in     = cdr_r;
   assign serial_driver_out = drv_out_r;
   // Each latch bit is the power enable of its driver, high meaning on.
   assign serial_driver_en  = latch_q;

   // Enable latch, fed from the enable bus register and the latch enable bit.
   spr_enable_latch u_latch (
      .clk      (aclk),
      .rst_n    (aresetn),
      .latch_en (le),
      .en_bus   (enbus_r),
      .en_out   (latch_q)
   );

   // Write address and data capture.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_held_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end
      else
      begin
         aw_held_r <= do_write ? 1'b0 : (aw_held_r || aw_take);
         w_held_r  <= do_write ? 1'b0 : (w_held_r || w_take);
         if (aw_take)
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
         if (w_take)
         begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
      end
   end

   // Write response.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= `SPR_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // Control registers.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r  <= `SPR_CTRL_RST;
         enbus_r <= `SPR_ENBUS_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_r <= ctrl_nxt;
         if (wr_enbus)
            enbus_r <= enbus_nxt;
      end
   end

   // Read channel; the answer follows one cycle after the address is taken.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `SPR_RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word;
         rresp_r  <= rd_hit ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // Serial path registers, cleared by the clocked reset so outputs are known at once.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cdr_r     <= 4'h0;
         drv_out_r <= 8'h00;
      end
      else
      begin
         cdr_r     <= cdr_nxt;
         drv_out_r <= drv_nxt;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_input_select: assert property (
      !lb |=> cdr_serial_in == (($past(sel) & $past(primary_serial_in)) |
                                (~$past(sel) & $past(secondary_serial_in))))
      else $error("Selected serial input did not reach recovery.");
   a_loop_route: assert property (
      lb |=> cdr_serial_in == $past(tx_serial_data))
      else $error("Loopback did not route transmit into recovery.");
   a_loop_ones: assert property (
      lb |=> (serial_driver_out & serial_driver_en) == serial_driver_en)
      else $error("Enabled driver not held at one in loopback.");
   a_loop_ignore: assert property (
      lb ##1 (lb && $stable(tx_serial_data)) |=> $stable(cdr_serial_in))
      else $error("External input leaked into recovery in loopback.");
   a_latch_open: assert property (
      le ##1 le |-> serial_driver_en == $past(enbus_r))
      else $error("Open latch did not follow the enable bus.");
   a_latch_hold: assert property (
      !le && $past(!le) |-> $stable(serial_driver_en))
      else $error("Closed latch changed its value.");
   a_reset_clear: assert property (
      disable iff (1'b0) !aresetn |=> serial_driver_en == 8'h00)
      else $error("Reset did not clear the driver enables.");
   a_reset_settle: assert property (
      disable iff (1'b0) $rose(aresetn) |->
      (serial_driver_en == 8'h00) && (cdr_serial_in == 4'h0))
      else $error("Outputs not settled at reset release.");
   a_driver_map: assert property (
      !lb |=> serial_driver_out == {2{$past(tx_serial_data)}})
      else $error("Transmit stream not mapped to both drivers.");
   a_write_resp: assert property (do_write |=> s_axi_bvalid)
      else $error("Write response missing after write.");

   c_loopback:    cover property (!lb ##1 lb ##1 lb);
   c_latch_close: cover property (le ##1 !le ##1 !le);
   c_write_done:  cover property (s_axi_bvalid && s_axi_bready);
   c_read_done:   cover property (s_axi_rvalid && s_axi_rready && (s_axi_rresp == `SPR_RESP_OKAY));

endmodule : spr_route_enable

/* File: spr_params.svh */
// Constants for the serial port route and enable block: offsets, fields, reset values, timing.
// Behaviour
// - Input select high passes primary serial input to recovery, low passes secondary.
// - Loopback routes each channel's transmit stream into its own receive recovery.
// - During loopback every enabled serial driver outputs a steady logic one.
// - During loopback both external serial inputs of every channel are ignored.
// - Latch enable high makes the output-enable latch follow the eight enable bits.
// - A driver is enabled when its enable bit is high, powered down when low.
// - Latch enable falling holds the last enable values; controller keeps bus stable.
// - Sampled reset clears the output-enable latch, disabling every serial driver.
// - Reset acts only on a clock edge; outputs settle within sixteen cycles.
`ifndef SPR_PARAMS_SVH
`define SPR_PARAMS_SVH

// Register byte offsets.
`define SPR_CTRL_OFF        8'h00
`define SPR_ENBUS_OFF       8'h04
`define SPR_STATUS_OFF      8'h08

// Control register fields.
`define SPR_CTRL_LOOP_BIT   0
`define SPR_CTRL_SEL_LSB    4
`define SPR_CTRL_LE_BIT     8
`define SPR_CTRL_MASK       32'h0000_01f1

// Status register fields.
`define SPR_STAT_EN_LSB     0
`define SPR_STAT_LOOP_BIT   8

// Reset values.
`define SPR_CTRL_RST        32'h0000_0000
`define SPR_ENBUS_RST       8'h00
`define SPR_LATCH_RST       8'h00

// Bus responses.
`define SPR_RESP_OKAY       2'b00
`define SPR_RESP_SLVERR     2'b10

// Longest settle time after reset release, in reference clock cycles.
`define SPR_SETTLE_CYC      16

`endif

/* File: spr_pkg.sv */
// Types and shared helpers of the serial port route and enable block.
package spr_pkg;

   typedef logic [3:0]  spr_chan_t;
   typedef logic [7:0]  spr_en_t;
   typedef logic [31:0] spr_word_t;

   // Merges a bus write into a stored word, byte lane by byte lane.
   function automatic spr_word_t spr_merge(input spr_word_t old_w,
                                           input spr_word_t new_w,
                                           input logic [3:0] strb);
      spr_word_t res;
      res = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return res;
   endfunction : spr_merge

endpackage : spr_pkg

/* File: spr_enable_latch.sv */
// Output-enable latch: following the bus one clock late while enabled, holding while closed, cleared by reset.
`include "spr_params.svh"
module spr_enable_latch
   import spr_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst_n,
   input  wire logic    latch_en,
   input  wire spr_en_t en_bus,
   output spr_en_t      en_out
);

   spr_en_t latch_r;
   spr_en_t latch_nxt;

   // Open latch follows the bus; a closed one keeps the value seen on its last open cycle.
   assign latch_nxt = latch_en ? en_bus : latch_r;
   assign en_out    = latch_r;

   // Reset is sampled on the clock like every other control input.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         latch_r <= `SPR_LATCH_RST;
      else
         latch_r <= latch_nxt;
   end

endmodule : spr_enable_latch

/* File: spr_far_model.sv */
// Far-side model: board logic feeding serial streams into the block.
module spr_far_model
   import spr_pkg::*;
(
   input  wire logic aclk,
   output spr_chan_t prim,
   output spr_chan_t sec,
   output spr_chan_t tx
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 84;

   // Every stream changes each cycle, so a path that should be ignored shows at once.
   // The streams are unknown only until the first edge, well inside the reset time.
   always @(posedge aclk)
   begin
      prim <= 4'($random(seed));
      sec  <= 4'($random(seed));
      tx   <= 4'($random(seed));
   end
endmodule : spr_far_model

/* File: test_serial_port_route_and_enable.sv */
// Self-checking bench for the serial port route and enable block.
`include "spr_params.svh"
module test_serial_port_route_and_enable
   import spr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, lp = 1'b0, chk = 1'b0;
   logic [1:0] bresp, rresp;
   spr_chan_t prim, sec, tx, clock_data_recovery, p_prim, p_sec, p_tx, exp_cdr, sel = 4'h0;
   spr_en_t drv_out, drv_en, lat = 8'h00;
   int err_total = 0, checks = 0, seed = 84;
   logic [33:0] rq[$];
   logic [1:0] bq[$];

   always #2 aclk = ~aclk;

   spr_route_enable uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .primary_serial_in(prim),
      .secondary_serial_in(sec), .tx_serial_data(tx), .cdr_serial_in(clock_data_recovery),
      .serial_driver_out(drv_out), .serial_driver_en(drv_en));

   spr_far_model far (.aclk(aclk), .prim(prim), .sec(sec), .tx(tx));

   task automatic cmp_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_bus

   task automatic cmp_ser(input string nm, input spr_en_t e, input spr_en_t g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_ser

   task automatic give_verdict();
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // A wait that used up its bound ends the run as a failure.
   task automatic tmo(input int n);
      if (n >= 50)
      begin
         err_total++;
         give_verdict();
      end
   endtask : tmo

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      int n;
      @(posedge aclk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         n++;
      end
      while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      tmo(n);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      rq.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         n++;
      end
      while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      tmo(n);
   endtask : rd

   // Control is written before the enable bus, so a closed latch never sees the new bus.
   task automatic cfg(input logic [8:0] c, input spr_en_t e);
      chk <= 1'b0;
      wr(`SPR_CTRL_OFF, {23'h00_0000, c}, 4'hf, `SPR_RESP_OKAY);
      wr(`SPR_ENBUS_OFF, {24'h00_0000, e}, 4'hf, `SPR_RESP_OKAY);
      lp = c[0];
      sel = c[7:4];
      if (c[8])
         lat = e;
      repeat (3) @(posedge aclk);
      chk <= 1'b1;
      repeat (6) @(posedge aclk);
      rd(`SPR_STATUS_OFF, {23'h00_0000, lp, lat}, `SPR_RESP_OKAY);
   endtask : cfg

   // Bus answers are matched against the oldest note; serial outputs against last cycle's inputs.
   always @(posedge aclk)
   begin
      if (bvalid === 1'b1 && bready === 1'b1)
         cmp_bus("bresp", {32'h0000_0000, bq.pop_front()}, {32'h0000_0000, bresp});
      if (rvalid === 1'b1 && rready === 1'b1)
         cmp_bus("read", rq.pop_front(), {rresp, rdata});
      if (chk)
      begin
         exp_cdr = lp ? p_tx : (sel & p_prim) | (~sel & p_sec);
         cmp_ser("cdr", {4'h0, exp_cdr}, {4'h0, clock_data_recovery});
         cmp_ser("drv_out", lp ? 8'hff : {p_tx, p_tx}, drv_out);
         cmp_ser("drv_en", lat, drv_en);
      end
      p_prim = prim;
      p_sec = sec;
      p_tx = tx;
   end

   // Main sequence: fixed corner cases first, then random settings, then strobe and bus error cases, then a mid-run reset.
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SPR_CTRL_OFF, 32'h0000_0000, `SPR_RESP_OKAY);
      rd(`SPR_STATUS_OFF, 32'h0000_0000, `SPR_RESP_OKAY);
      cfg(9'h0f0, 8'h00);
      cfg(9'h000, 8'h00);
      cfg(9'h1a1, 8'h5a);
      cfg(9'h051, 8'h3c);
      for (int i = 0; i < 8; i++)
         cfg({1'($random(seed)), 4'($random(seed)), 3'h0, 1'($random(seed))},
             8'($random(seed)));
      cfg(9'h000, 8'hc3);
      chk <= 1'b0;
      wr(`SPR_CTRL_OFF, 32'h0000_01ff, 4'h2, `SPR_RESP_OKAY);
      lat = 8'hc3;
      rd(`SPR_CTRL_OFF, 32'h0000_0100, `SPR_RESP_OKAY);
      wr(8'h0c, 32'hffff_ffff, 4'hf, `SPR_RESP_SLVERR);
      rd(8'h0c, 32'h0000_0000, `SPR_RESP_SLVERR);
      wr(`SPR_STATUS_OFF, 32'h0000_0000, 4'hf, `SPR_RESP_OKAY);
      rd(`SPR_STATUS_OFF, 32'h0000_00c3, `SPR_RESP_OKAY);
      cfg(9'h101, 8'hff);
      chk <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      lp = 1'b0;
      sel = 4'h0;
      lat = 8'h00;
      repeat (2) @(posedge aclk);
      chk <= 1'b1;
      repeat (12) @(posedge aclk);
      rd(`SPR_STATUS_OFF, 32'h0000_0000, `SPR_RESP_OKAY);
      repeat (2) @(posedge aclk);
      give_verdict();
   end
endmodule : test_serial_port_route_and_enable
